/* File: verilog/sfs_frame_status.sv */
// Contract
// - FIFO active only when enabled and SDLC
// - Pointers clear when disabled or reset
// - FIFO enable bit resets to zero
// - Disabled: alias reads mirror base status registers
// - Enabled, not empty: views read FIFO head, except status stays live after an empty count-high read
// - One pop per status read, guarded
// - Empty: no underflow, live status used
// - Count-high bit 6 shows data available
// - Entry stores residue, overrun, CRC only
// - Count-high read latches flag, steers mux
// - End of frame pushes status and count
// - Overflow flag clears by disable/re-enable
// - Fourteen-bit received byte counter
// - Counter runs only when enabled and SDLC
// - Flag clears counter after capture
// - Counter increments per data FIFO write
// - Enhancement bit redirects flag register writes
// - Extended read exposes write-only registers
// - Enabled map: count views, aliases, mirror
// - Entry is count plus five status
// - Ten entries held before overflow
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sfs_status_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 10
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  input  wire logic             clear_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready_out  = (fill != (AW+1)'(DEPTH));
  assign out_valid_out = (fill != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_ready_in && out_valid_out;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else if (clear_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wrap_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= wrap_inc(rd_ptr);
      end
      if (push && !pop) begin
        fill <= fill + (AW+1)'(1);
      end else if (pop && !push) begin
        fill <= fill - (AW+1)'(1);
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sfs_frame_status (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  input  wire logic                  chan_reset_in,
  // Register port
  input  wire sfs_pkg::sfs_reg_req_type reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  // Receiver events and mode
  input  wire logic                  sdlc_mode_in,
  input  wire logic                  rx_data_write_in,
  input  wire logic                  rx_flag_in,
  input  wire logic                  rx_eof_in,
  // Live status from the channel core
  input  wire logic [7:0]            tx_rx_status_in,
  input  wire logic [7:0]            rx_special_status_in,
  input  wire logic [7:0]            vector_in,
  input  wire logic [7:0]            pending_in,
  input  wire logic [7:0]            ext_int_enable_in,
  // Written configuration towards the channel
  output logic [7:0]                 feature_enable_out,
  output logic [7:0]                 enhancement_ctrl_out,
  output logic [7:0]                 flag_pattern_out,
  output logic [7:0]                 rx_param_out,
  output logic [7:0]                 line_ctrl_out,
  output logic                       fifo_enabled_out
);
  logic                  rst_meta;
  logic                  rst_n;
  logic [7:0]            feature_enable_reg;
  logic [7:0]            enhancement_ctrl_reg;
  logic [7:0]            flag_pattern_reg;
  logic [7:0]            rx_param_reg;
  logic [7:0]            line_ctrl_reg;
  logic [13:0]           byte_count;
  logic                  overflow;
  logic                  avail_latched;
  logic                  pop_armed;
  logic                  fifo_en;
  logic                  ext_read;
  logic                  in_ready;
  logic                  head_valid;
  logic                  pop;
  logic                  push;
  logic [18:0]           head_raw;
  sfs_pkg::sfs_entry_type head;
  sfs_pkg::sfs_entry_type new_entry;
  logic [7:0]            next_rdata;
  logic [7:0]            special_view;
  logic [7:0]            ext_view;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign fifo_en  = feature_enable_reg[sfs_pkg::FEAT_FIFO_BIT] && sdlc_mode_in;
  assign ext_read = feature_enable_reg[sfs_pkg::FEAT_ENH_BIT]
                    && enhancement_ctrl_reg[sfs_pkg::ENH_EXT_RD_BIT];
  assign fifo_enabled_out = fifo_en;

  // Register writes
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      feature_enable_reg   <= sfs_pkg::FEATURE_RST;
      enhancement_ctrl_reg <= sfs_pkg::ENH_RST;
      flag_pattern_reg     <= sfs_pkg::FLAG_RST;
      rx_param_reg         <= sfs_pkg::WO_RST;
      line_ctrl_reg        <= sfs_pkg::WO_RST;
    end else if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        sfs_pkg::REG_FEATURE: begin
          feature_enable_reg <= reg_req_in.wdata;
        end
        sfs_pkg::REG_FLAG_PAT: begin
          if (feature_enable_reg[sfs_pkg::FEAT_ENH_BIT]) begin
            enhancement_ctrl_reg <= reg_req_in.wdata;
            enhancement_ctrl_reg[sfs_pkg::ENH_ZERO_BIT] <= 1'b0;
          end else begin
            flag_pattern_reg <= reg_req_in.wdata;
          end
        end
        sfs_pkg::REG_RX_PARAM: begin
          rx_param_reg <= reg_req_in.wdata;
        end
        sfs_pkg::REG_LINE_CTRL: begin
          line_ctrl_reg <= reg_req_in.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  assign feature_enable_out   = feature_enable_reg;
  assign enhancement_ctrl_out = enhancement_ctrl_reg;
  assign flag_pattern_out     = flag_pattern_reg;
  assign rx_param_out         = rx_param_reg;
  assign line_ctrl_out        = line_ctrl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte counter; flag clear lands on the same edge at which the push samples it
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      byte_count <= '0;
    end else if (!fifo_en) begin
      byte_count <= '0;
    end else if (rx_flag_in) begin
      byte_count <= '0;
    end else if (rx_data_write_in) begin
      byte_count <= byte_count + 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status FIFO: only residue, overrun and CRC travel with the count
  always_comb begin
    new_entry.count   = byte_count;
    new_entry.crc_err = rx_special_status_in[sfs_pkg::STAT_CRC_BIT];
    new_entry.overrun = rx_special_status_in[sfs_pkg::STAT_OVR_BIT];
    new_entry.residue = rx_special_status_in[sfs_pkg::STAT_RES_LO +: 3];
  end

  assign push = fifo_en && rx_eof_in && !overflow;

  sfs_status_fifo #(
    .WIDTH (sfs_pkg::ENTRY_W),
    .DEPTH (sfs_pkg::STAT_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rstn_in       (rst_n),
    .clear_in      (!fifo_en || chan_reset_in),
    .in_valid_in   (push),
    .in_ready_out  (in_ready),
    .in_data_in    (new_entry),
    .out_valid_out (head_valid),
    .out_ready_in  (pop),
    .out_data_out  (head_raw)
  );
  assign head = sfs_pkg::sfs_entry_type'(head_raw);

  // Overflow freezes the queue; only a disable or a channel reset clears it
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (!fifo_en || chan_reset_in) begin
      overflow <= 1'b0;
    end else if (fifo_en && rx_eof_in && !in_ready) begin
      overflow <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count-high read arms one pop; repeated status reads cannot drain more.
  // An empty count-high read keeps the next status read on the live path,
  // so a frame landing in between is not shown without its count.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      avail_latched <= 1'b1;
      pop_armed     <= 1'b0;
    end else if (!fifo_en || chan_reset_in) begin
      avail_latched <= 1'b1;
      pop_armed     <= 1'b0;
    end else if (reg_req_in.rd && reg_req_in.addr == sfs_pkg::REG_COUNT_HIGH) begin
      avail_latched <= head_valid;
      pop_armed     <= head_valid;
    end else if (reg_req_in.rd && reg_req_in.addr == sfs_pkg::REG_SPECIAL) begin
      avail_latched <= 1'b1;
      pop_armed     <= 1'b0;
    end
  end

  assign pop = reg_req_in.rd && reg_req_in.addr == sfs_pkg::REG_SPECIAL
               && fifo_en && pop_armed && head_valid;

  // Status view: FIFO bits while data sits in it, unless a count-high read since the last status read found it empty; else live
  always_comb begin
    special_view = rx_special_status_in;
    if (fifo_en && head_valid && avail_latched) begin
      special_view[sfs_pkg::STAT_RES_LO +: 3] = head.residue;
      special_view[sfs_pkg::STAT_OVR_BIT]     = head.overrun;
      special_view[sfs_pkg::STAT_CRC_BIT]     = head.crc_err;
    end
  end

  always_comb begin
    ext_view = ext_int_enable_in;
    ext_view[sfs_pkg::EXTIE_FIFO_BIT] = fifo_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    next_rdata = 8'h00;
    case (reg_req_in.addr)
      sfs_pkg::REG_STATUS:  next_rdata = tx_rx_status_in;
      sfs_pkg::REG_SPECIAL: next_rdata = special_view;
      sfs_pkg::REG_VECTOR:  next_rdata = vector_in;
      sfs_pkg::REG_PENDING: next_rdata = pending_in;
      sfs_pkg::REG_ALIAS_FOUR: begin
        next_rdata = tx_rx_status_in;
      end
      sfs_pkg::REG_ALIAS_FIVE: begin
        next_rdata = special_view;
      end
      sfs_pkg::REG_COUNT_LOW: begin
        // Stale head bits when empty; software must check availability
        next_rdata = fifo_en ? head.count[7:0] : vector_in;
      end
      sfs_pkg::REG_COUNT_HIGH: begin
        if (fifo_en) begin
          next_rdata = {overflow, head_valid, head.count[13:8]};
        end else begin
          next_rdata = pending_in;
        end
      end
      sfs_pkg::REG_SHADOW_9: begin
        next_rdata = ext_read ? rx_param_reg : 8'h00;
      end
      sfs_pkg::REG_SHADOW_11: begin
        if (ext_read) begin
          next_rdata = line_ctrl_reg;
        end else if (fifo_en) begin
          next_rdata = ext_view;
        end
      end
      sfs_pkg::REG_SHADOW_14: begin
        next_rdata = ext_read ? enhancement_ctrl_reg : 8'h00;
      end
      sfs_pkg::REG_FEATURE: next_rdata = ext_view;
      default:              next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sfs_pkg.sv */
`default_nettype none
package sfs_pkg;
  // Register numbers on the register port (point-high registers are 8..15)
  localparam logic [3:0] REG_STATUS     = 4'h0;
  localparam logic [3:0] REG_SPECIAL    = 4'h1;
  localparam logic [3:0] REG_VECTOR     = 4'h2;
  localparam logic [3:0] REG_PENDING    = 4'h3;
  localparam logic [3:0] REG_ALIAS_FOUR = 4'h4;
  localparam logic [3:0] REG_ALIAS_FIVE = 4'h5;
  localparam logic [3:0] REG_COUNT_LOW  = 4'h6;
  localparam logic [3:0] REG_COUNT_HIGH = 4'h7;
  localparam logic [3:0] REG_SHADOW_9   = 4'h9;
  localparam logic [3:0] REG_LINE_CTRL  = 4'ha;
  localparam logic [3:0] REG_SHADOW_11  = 4'hb;
  localparam logic [3:0] REG_SHADOW_14  = 4'he;
  localparam logic [3:0] REG_FEATURE    = 4'hf;
  localparam logic [3:0] REG_RX_PARAM   = 4'h3;
  localparam logic [3:0] REG_FLAG_PAT   = 4'h7;

  // Field positions
  localparam int FEAT_ENH_BIT     = 0;
  localparam int FEAT_FIFO_BIT    = 2;
  localparam int ENH_EXT_RD_BIT   = 6;
  localparam int ENH_ZERO_BIT     = 7;
  localparam int CNTH_AVAIL_BIT   = 6;
  localparam int CNTH_OVF_BIT     = 7;
  localparam int EXTIE_FIFO_BIT   = 2;
  localparam int STAT_RES_LO      = 1;
  localparam int STAT_OVR_BIT     = 5;
  localparam int STAT_CRC_BIT     = 6;

  // Reset values
  localparam logic [7:0] FEATURE_RST  = 8'h00;
  localparam logic [7:0] ENH_RST      = 8'h00;
  localparam logic [7:0] FLAG_RST     = 8'h7e;
  localparam logic [7:0] WO_RST       = 8'h00;

  // Status FIFO shape
  localparam int COUNT_W    = 14;
  localparam int STAT_DEPTH = 10;
  localparam int ENTRY_W    = 19;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic               crc_err;
    logic               overrun;
    logic [2:0]         residue;
  } sfs_entry_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } sfs_reg_req_type;
endpackage
`default_nettype wire

/* File: dv/sfs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_chk (
  // Clock and reset
  input wire logic                     clk_sys_in,
  input wire logic                     rstn_in,
  // Register port
  input wire sfs_pkg::sfs_reg_req_type reg_req_in,
  input wire logic [7:0]               reg_rdata_out,
  // Mode, events and live status
  input wire logic                     sdlc_mode_in,
  input wire logic                     rx_eof_in,
  input wire logic [7:0]               tx_rx_status_in,
  input wire logic [7:0]               rx_special_status_in,
  input wire logic [7:0]               vector_in,
  input wire logic [7:0]               pending_in,
  // Configuration
  input wire logic [7:0]               feature_enable_out,
  input wire logic [7:0]               enhancement_ctrl_out,
  input wire logic [7:0]               flag_pattern_out,
  input wire logic [7:0]               rx_param_out,
  input wire logic                     fifo_enabled_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire logic [3:0] ad = reg_req_in.addr;
  wire logic       rd = reg_req_in.rd;
  wire logic       xr = feature_enable_out[0] & enhancement_ctrl_out[6];
  ////////////////////////////////////////
  chk_enable_gate: assert property (
    fifo_enabled_out == (feature_enable_out[2] && sdlc_mode_in)) else $error("enable gate");
  chk_enable_view: assert property (rd && ad == 4'hf |=>
    reg_rdata_out[2] == $past(fifo_enabled_out)) else $error("enable view bit");
  chk_alias_four: assert property (rd && ad == 4'h4 |=>
    reg_rdata_out == $past(tx_rx_status_in)) else $error("alias four view");
  chk_alias_low: assert property (rd && ad == 4'h6 && !fifo_enabled_out |=>
    reg_rdata_out == $past(vector_in)) else $error("count low alias");
  chk_alias_high: assert property (rd && ad == 4'h7 && !fifo_enabled_out |=>
    reg_rdata_out == $past(pending_in)) else $error("count high alias");
  chk_live_bits: assert property (rd && ad == 4'h1 |=>
    {reg_rdata_out[7], reg_rdata_out[4], reg_rdata_out[0]} ==
    $past({rx_special_status_in[7], rx_special_status_in[4], rx_special_status_in[0]}))
    else $error("live status bits");
  chk_flag_redirect: assert property (
    reg_req_in.wr && ad == 4'h7 && feature_enable_out[0] |=> $stable(flag_pattern_out))
    else $error("flag pattern written");
  chk_ext_fourteen: assert property (rd && ad == 4'he && xr |=>
    reg_rdata_out == $past(enhancement_ctrl_out)) else $error("shadow fourteen");
  chk_ext_nine: assert property (rd && ad == 4'h9 && xr |=>
    reg_rdata_out == $past(rx_param_out)) else $error("shadow nine");
  cover property (rd && ad == 4'h7 ##1 reg_rdata_out[6]);
  cover property (rd && ad == 4'h7 ##1 reg_rdata_out[7]);
  cover property (rx_eof_in && fifo_enabled_out);
endmodule
bind sfs_frame_status sfs_chk u_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .sdlc_mode_in(sdlc_mode_in), .rx_eof_in(rx_eof_in),
  .tx_rx_status_in(tx_rx_status_in), .rx_special_status_in(rx_special_status_in),
  .vector_in(vector_in), .pending_in(pending_in), .feature_enable_out(feature_enable_out),
  .enhancement_ctrl_out(enhancement_ctrl_out), .flag_pattern_out(flag_pattern_out),
  .rx_param_out(rx_param_out), .fifo_enabled_out(fifo_enabled_out)
);
`default_nettype wire

/* File: dv/sfs_rx_source.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_rx_source (
  // Control from the bench
  input  wire logic        clk_sys_in,
  input  wire logic        start_in,
  input  wire logic [13:0] len_in,
  input  wire logic        slow_in,
  // Receiver events
  output logic             rx_data_write_out,
  output logic             rx_flag_out,
  output logic             rx_eof_out,
  output logic             busy_out
);
  int n;
  initial begin
    {rx_data_write_out, rx_flag_out, rx_eof_out, busy_out} = 4'h0;
    forever begin
      @(posedge clk_sys_in);
      if (start_in) begin
        n = len_in;
        busy_out <= 1'b1;
        rx_flag_out <= 1'b1;
        @(posedge clk_sys_in);
        rx_flag_out <= 1'b0;
        // One write per byte, slow mode leaves gaps
        for (int i = 0; i < n; i++) begin
          rx_data_write_out <= 1'b1;
          @(posedge clk_sys_in);
          if (slow_in) begin
            rx_data_write_out <= 1'b0;
            @(posedge clk_sys_in);
          end
        end
        // Closing flag comes with the end of frame
        rx_data_write_out <= 1'b0;
        rx_eof_out <= 1'b1;
        rx_flag_out <= 1'b1;
        @(posedge clk_sys_in);
        {rx_eof_out, rx_flag_out, busy_out} <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, chan_reset_in = 1'b0, sdlc = 1'b1;
  logic start = 1'b0, slow = 1'b0, ovf = 1'b0, wb, fb, eb, busy, en;
  logic [13:0] len = 14'h0000;
  logic [7:0] st0 = 8'h00, st1 = 8'h00, vec = 8'h00, pend = 8'h00, ext = 8'h00;
  logic [7:0] rdata, feat, enh, flagp, rxp, lc, d, w, x;
  sfs_pkg::sfs_reg_req_type req = '0;
  sfs_pkg::sfs_entry_type q[$], e;
  int seed = 32'h602df87a, err_total = 0, checks = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  sfs_frame_status u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .chan_reset_in(chan_reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .sdlc_mode_in(sdlc), .rx_data_write_in(wb), .rx_flag_in(fb), .rx_eof_in(eb),
    .tx_rx_status_in(st0), .rx_special_status_in(st1), .vector_in(vec), .pending_in(pend),
    .ext_int_enable_in(ext), .feature_enable_out(feat), .enhancement_ctrl_out(enh),
    .flag_pattern_out(flagp), .rx_param_out(rxp), .line_ctrl_out(lc), .fifo_enabled_out(en));
  sfs_rx_source u_src (.clk_sys_in(clk_sys_in), .start_in(start), .len_in(len),
    .slow_in(slow), .rx_data_write_out(wb), .rx_flag_out(fb), .rx_eof_out(eb),
    .busy_out(busy));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] v);
    @(negedge clk_sys_in);
    req = {r, ~r, a, v};
    @(negedge clk_sys_in);
    req = '0;
    d = rdata;
  endtask
  function automatic logic [7:0] fst(input sfs_pkg::sfs_entry_type y, input logic [7:0] l);
    return {l[7], y.crc_err, y.overrun, l[4], y.residue, l[0]};
  endfunction
  task automatic frame(input logic [13:0] n, input logic push);
    st1 = 8'($random(seed));
    slow = 1'($random(seed));
    len = n;
    @(negedge clk_sys_in);
    start = 1'b1;
    @(negedge clk_sys_in);
    start = 1'b0;
    for (int i = 0; i < 40000 && busy; i++) @(negedge clk_sys_in);
    // A frame that never ends is a failure, not a silent skip
    if (busy) err_total++;
    e = '{count: n, crc_err: st1[6], overrun: st1[5], residue: st1[3:1]};
    if (push && q.size() < sfs_pkg::STAT_DEPTH) q.push_back(e);
    else if (push) ovf = 1'b1;
  endtask
  // Host reads count high, count low, then status, as it must
  task automatic drain(input logic extra);
    while (q.size() > 0) begin
      e = q.pop_front();
      acc(1'b1, 4'h7, 8'h00);
      chk("count_high", d, {ovf, 1'b1, e.count[13:8]});
      acc(1'b1, 4'h6, 8'h00);
      chk("count_low", d, e.count[7:0]);
      st1 = 8'($random(seed));
      acc(1'b1, 4'h1, 8'h00);
      chk("status", d, fst(e, st1));
      if (extra) acc(1'b1, 4'h1, 8'h00);
    end
    acc(1'b1, 4'h7, 8'h00);
    chk("empty_flags", d[7:6], {ovf, 1'b0});
    st1 = 8'($random(seed));
    acc(1'b1, 4'h1, 8'h00);
    chk("live_status", d, st1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk("feature_rst", feat, sfs_pkg::FEATURE_RST);
    chk("flag_rst", flagp, sfs_pkg::FLAG_RST);
    for (int i = 0; i < 4; i++) begin
      {st0, st1, vec, pend} = $random(seed);
      ext = 8'($random(seed));
      acc(1'b1, 4'h4 + 4'(i), 8'h00);
      chk("alias", d, i == 0 ? st0 : i == 1 ? st1 : i == 2 ? vec : pend);
    end
    acc(1'b1, 4'hf, 8'h00);
    chk("view_off", d[2], 1'b0);
    $display("test disabled done");
    acc(1'b0, 4'hf, 8'h05);
    chk("enabled", en, 1'b1);
    acc(1'b1, 4'hf, 8'h00);
    chk("view_on", d[2], 1'b1);
    x = 8'($random(seed));
    acc(1'b0, 4'h7, x | 8'h40);
    chk("enh_ctrl", enh, (x | 8'h40) & 8'h7f);
    chk("flag_kept", flagp, sfs_pkg::FLAG_RST);
    w = 8'($random(seed));
    acc(1'b0, 4'h3, w);
    acc(1'b0, 4'ha, w ^ 8'hff);
    chk("rx_param", rxp, w);
    chk("line_ctrl", lc, w ^ 8'hff);
    acc(1'b1, 4'h9, 8'h00);
    chk("shadow9", d, w);
    acc(1'b1, 4'hb, 8'h00);
    chk("shadow11", d, w ^ 8'hff);
    acc(1'b1, 4'he, 8'h00);
    chk("shadow14", d, (x | 8'h40) & 8'h7f);
    $display("test registers done");
    repeat (6) frame(14'(1 + ($random(seed) & 31)), 1'b1);
    drain(1'b1);
    frame(14'h3fff, 1'b1);
    drain(1'b0);
    $display("test frames done");
    repeat (11) frame(14'(1 + ($random(seed) & 7)), 1'b1);
    drain(1'b0);
    acc(1'b0, 4'hf, 8'h01);
    acc(1'b0, 4'hf, 8'h05);
    ovf = 1'b0;
    acc(1'b1, 4'h7, 8'h00);
    chk("ovf_clear", d[7:6], 2'h0);
    $display("test overflow done");
    sdlc = 1'b0;
    frame(14'h0003, 1'b0);
    chk("sdlc_off", en, 1'b0);
    sdlc = 1'b1;
    drain(1'b0);
    // Empty count-high read, then a frame lands before the status read
    acc(1'b1, 4'h7, 8'h00);
    frame(14'h0006, 1'b1);
    st1 = fst(e, 8'($random(seed))) ^ 8'h6e;
    acc(1'b1, 4'h1, 8'h00);
    chk("steer_live", d, st1);
    drain(1'b0);
    frame(14'h0004, 1'b1);
    frame(14'h0005, 1'b1);
    @(negedge clk_sys_in);
    chan_reset_in = 1'b1;
    @(negedge clk_sys_in);
    chan_reset_in = 1'b0;
    q.delete();
    drain(1'b0);
    acc(1'b0, 4'hf, 8'h04);
    acc(1'b1, 4'hb, 8'h00);
    chk("shadow11_ext", d, {ext[7:3], 1'b1, ext[1:0]});
    $display("test resets done");
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
